// ---- inc/gpio_pkg.sv ----
// Constants shared by the dual GPIO port block: register indices, field
// positions, reset values and operation codes.
// Assumes a 32-bit APB bus; byte address of a register is four times its index.
`default_nettype none

package gpio_pkg;

  // Port widths
  localparam int PA_W  = 5;
  localparam int PB_W  = 8;
  localparam int DAT_W = 8;
  localparam int IDX_W = 8;

  // Register indices; byte address = index * 4
  localparam logic [IDX_W-1:0] IDX_PORT_A  = 8'h05;
  localparam logic [IDX_W-1:0] IDX_PORT_B  = 8'h06;
  localparam logic [IDX_W-1:0] IDX_INT_CTL = 8'h0b;
  localparam logic [IDX_W-1:0] IDX_BIT_OP  = 8'h0c;
  localparam logic [IDX_W-1:0] IDX_CMP_CTL = 8'h1f;
  localparam logic [IDX_W-1:0] IDX_OPTION  = 8'h81;
  localparam logic [IDX_W-1:0] IDX_DIR_A   = 8'h85;
  localparam logic [IDX_W-1:0] IDX_DIR_B   = 8'h86;
  localparam logic [IDX_W-1:0] IDX_VREF    = 8'h9f;

  // Reset values
  localparam logic [DAT_W-1:0] OPTION_RST = 8'hff;
  localparam logic [PA_W-1:0]  DIR_A_RST  = 5'h1f;
  localparam logic [PB_W-1:0]  DIR_B_RST  = 8'hff;
  localparam logic [3:0]       CMP_RST    = 4'h0;
  localparam logic [DAT_W-1:0] VREF_RST   = 8'h00;
  localparam logic [DAT_W-1:0] VREF_MASK  = 8'hef;
  localparam logic [PA_W-1:0]  LATCH_A_POR = 5'h00;
  localparam logic [PB_W-1:0]  LATCH_B_POR = 8'h00;

  // Field positions
  localparam int OPT_PULLUP_N_BIT = 7;
  localparam int INT_FLAG_BIT     = 0;
  localparam int INT_EXT_EN_BIT   = 4;
  localparam int VREF_EN_BIT      = 7;
  localparam int VREF_OE_BIT      = 6;
  localparam int CMP_OUT_LSB      = 6;
  localparam int BOP_BIT_LSB      = 0;
  localparam int BOP_PORT_BIT     = 3;
  localparam int BOP_OP_LSB       = 4;
  localparam int CHG_LSB          = 4;

  // Comparator modes seen by the pins
  localparam logic [2:0] CM_DIGITAL = 3'h7;
  localparam logic [2:0] CM_PIN_OUT = 3'h6;

  // Bit operation codes
  typedef enum logic [1:0] {
    BOP_NONE   = 2'h0,
    BOP_SET    = 2'h1,
    BOP_CLEAR  = 2'h2,
    BOP_TOGGLE = 2'h3
  } bit_op_t;

endpackage : gpio_pkg

`default_nettype wire

// ---- src/gpio_pin_cell.sv ----
// One pin output stage: push-pull or open-drain, with alternate drive.
// Assumes dir_in is 1 for input (driver off) and that the pad resolves oe.
`default_nettype none

module gpio_pin_cell #(
  parameter bit OPEN_DRAIN = 1'b0
) (
  input  wire logic i_dir_in,   // 1 = pin is input
  input  wire logic i_latch,    // Output latch bit
  input  wire logic i_alt_en,   // Alternate function owns the value
  input  wire logic i_alt_val,  // Alternate output value
  input  wire logic i_force_off,// Driver released regardless of direction
  output var  logic o_out,      // Pad output value
  output var  logic o_oe        // Pad output enable, high = driving
);

  logic drive_val;

  // Open drain only ever pulls low, so a high drive_val (latch, or alternate value when enabled) releases the pad
  always_comb begin
    drive_val = i_alt_en ? i_alt_val : i_latch;
    if (OPEN_DRAIN) begin
      o_out = 1'b0;
      o_oe  = ~i_force_off & ~i_dir_in & ~drive_val;
    end else begin
      o_out = drive_val;
      o_oe  = ~i_force_off & ~i_dir_in;
    end
  end

endmodule : gpio_pin_cell

`default_nettype wire

// ---- src/gpio_dual_port.sv ----
// Dual GPIO port (5-bit A, 8-bit B) behind an APB slave, with pull-ups
// and a pin-change detector on the upper four B pins.
// Assumes pins are synchronous to I_CLK; comparator, reference and timer
// logic live outside and only see the control and status ports here.
//
// Overview of operation
// - B direction one tri-states, zero drives
// - Data read returns pins, write hits latch
// - Bit operations are read-modify-write; plain port writes are not
// - Active-low option bit 7 enables B pull-ups
// - Output-configured B pins lose their pull-up
// - Pull-ups off at power-on, option resets ones
// - Upper B pins vs reference set change flag
// - Output-configured upper pins excluded from compare
// - Change flag wakes device from sleep
// - Mismatch keeps flag set; B access ends it
// - Change during read sample still sets the flag
// - A bit 4 open-drain, timer clock, comparator
// - A bits 0-3 comparator inputs, reference, output
// - B bit 0 external interrupt, Schmitt buffer
// - B bits 6,7 programming clock and data
// - Directions reset ones; B latch kept otherwise
// - A direction resets 1 1111, data x 0000
// - Unimplemented register bits read zero
// - Bit operation rewrites latch from pin levels
// - A direction controls driver even when analog
// - Comparator-input A pins read zero
// - Read samples early, write lands late
`default_nettype none

module gpio_dual_port
  import gpio_pkg::*;
(
  input  wire logic                  I_CLK,        // 10 MHz clock
  input  wire logic                  I_SYS_RST,    // Sync reset, active high
  input  wire logic                  I_POR_FLAG,   // Reset is power-on/brown-out
  input  wire logic                  PSEL,         // APB select
  input  wire logic                  PENABLE,      // APB access phase
  input  wire logic                  PWRITE,       // APB direction
  input  wire logic [11:0]           PADDR,        // APB byte address
  input  wire logic [31:0]           PWDATA,       // APB write data
  input  wire logic [3:0]            PSTRB,        // APB byte strobes
  output var  logic                  PREADY,       // APB ready
  output var  logic [31:0]           PRDATA,       // APB read data
  output var  logic                  PSLVERR,      // APB error, unmapped
  input  wire logic [gpio_pkg::PA_W-1:0] I_PA_PIN, // Port A pin levels
  output var  logic [gpio_pkg::PA_W-1:0] O_PA_OUT, // Port A pad values
  output var  logic [gpio_pkg::PA_W-1:0] O_PA_OE,  // Port A pad enables
  input  wire logic [gpio_pkg::PB_W-1:0] I_PB_PIN, // Port B pin levels
  output var  logic [gpio_pkg::PB_W-1:0] O_PB_OUT, // Port B pad values
  output var  logic [gpio_pkg::PB_W-1:0] O_PB_OE,  // Port B pad enables
  output var  logic [gpio_pkg::PB_W-1:0] O_PB_PULLUP,  // Weak pull-up on
  output var  logic [gpio_pkg::PB_W-1:0] O_PB_SCHMITT, // Schmitt buffer sel
  input  wire logic [1:0]            I_CMP_OUT,    // Comparator results
  input  wire logic                  I_PROG_MODE,  // Serial programming mode
  input  wire logic                  I_SLEEP,      // Core is asleep
  output var  logic [3:0]            O_CMP_CTL,    // Input switch and mode
  output var  logic [7:0]            O_VREF_CTL,   // Reference control
  output var  logic                  O_VREF_PIN_EN,// Reference out on A2
  output var  logic                  O_TIMER_EXT_CLK, // A4 level to timer
  output var  logic                  O_EXT_INT_IN, // B0 level to interrupt
  output var  logic                  O_EXT_INT_EN, // External int enabled
  output var  logic                  O_PROG_CLK,   // B6 in programming mode
  output var  logic                  O_PROG_DATA,  // B7 in programming mode
  output var  logic                  O_CHANGE_FLAG,// Pin-change flag
  output var  logic                  O_WAKE        // Wake request
);

  import gpio_pkg::*;

  logic [PA_W-1:0]  pa_dir_reg;
  logic [PA_W-1:0]  pa_latch_reg;
  logic [PB_W-1:0]  pb_dir_reg;
  logic [PB_W-1:0]  pb_latch_reg;
  logic [DAT_W-1:0] option_reg;
  logic [3:0]       cmp_ctl_reg;
  logic [DAT_W-1:0] vref_reg;
  logic             ext_int_en_reg;
  logic             change_flag_reg;
  logic [3:0]       change_ref_reg;
  logic [31:0]      prdata_reg;
  logic             slverr_reg;

  logic             setup;
  logic             wr_commit;
  logic [IDX_W-1:0] idx;
  logic             mapped;
  logic [DAT_W-1:0] rd_mux;
  logic [3:0]       analog_mask;
  logic             cmp_pin_out;
  logic [DAT_W-1:0] pa_read;
  logic [2:0]       bop_bit;
  logic             bop_port_b;
  bit_op_t          bop_kind;
  logic             bop_go;
  logic [DAT_W-1:0] bop_src;
  logic [DAT_W-1:0] bop_result;
  logic             pb_touch;
  logic             mismatch;
  logic             flag_write;

  // Bus phase decode; upper address bits beyond the map are unmapped
  assign setup     = PSEL & ~PENABLE;
  assign idx       = PADDR[9:2];
  assign wr_commit = PSEL & PENABLE & PWRITE & PSTRB[0] & mapped;
  assign PREADY    = 1'b1;
  assign PRDATA    = prdata_reg;
  assign PSLVERR   = PSEL & PENABLE & slverr_reg;

  always_comb begin
    case (idx)
      IDX_PORT_A, IDX_PORT_B, IDX_INT_CTL, IDX_BIT_OP, IDX_CMP_CTL,
      IDX_OPTION, IDX_DIR_A, IDX_DIR_B, IDX_VREF: mapped = (PADDR[11:10] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end

  // Analog selection: all comparator modes except off claim A0-A3
  assign analog_mask = (cmp_ctl_reg[2:0] != CM_DIGITAL) ? 4'hf : 4'h0;
  assign cmp_pin_out = (cmp_ctl_reg[2:0] == CM_PIN_OUT);
  assign pa_read     = {3'h0, I_PA_PIN & ~{1'b0, analog_mask}};

  // Read mux; unimplemented bits are tied low
  always_comb begin
    case (idx)
      IDX_PORT_A:  rd_mux = pa_read;
      IDX_PORT_B:  rd_mux = I_PB_PIN;
      IDX_INT_CTL: rd_mux = {3'h0, ext_int_en_reg, 3'h0, change_flag_reg};
      IDX_CMP_CTL: rd_mux = {I_CMP_OUT, 2'h0, cmp_ctl_reg};
      IDX_OPTION:  rd_mux = option_reg;
      IDX_DIR_A:   rd_mux = {3'h0, pa_dir_reg};
      IDX_DIR_B:   rd_mux = pb_dir_reg;
      IDX_VREF:    rd_mux = vref_reg & VREF_MASK;
      default:     rd_mux = 8'h00;
    endcase
  end

  // Read data caught in the setup cycle: pins sampled early in the access
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      prdata_reg <= 32'h0;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= mapped ? {24'h0, rd_mux} : 32'h0;
      slverr_reg <= ~mapped;
    end
  end

  // Bit operation: port pins are the source, never the latch
  assign bop_bit    = PWDATA[BOP_BIT_LSB +: 3];
  assign bop_port_b = PWDATA[BOP_PORT_BIT];
  assign bop_kind   = bit_op_t'(PWDATA[BOP_OP_LSB +: 2]);
  assign bop_go     = wr_commit & (idx == IDX_BIT_OP) & (bop_kind != BOP_NONE);
  assign bop_src    = bop_port_b ? I_PB_PIN : pa_read;

  always_comb begin
    bop_result = bop_src;
    case (bop_kind)
      BOP_SET:    bop_result[bop_bit] = 1'b1;
      BOP_CLEAR:  bop_result[bop_bit] = 1'b0;
      BOP_TOGGLE: bop_result[bop_bit] = ~bop_src[bop_bit];
      default:    bop_result = bop_src;
    endcase
  end

  // Port latches: cleared only by power-on, kept across other resets
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      if (I_POR_FLAG) begin
        pa_latch_reg <= LATCH_A_POR;
        pb_latch_reg <= LATCH_B_POR;
      end
    end else if (wr_commit && idx == IDX_PORT_A) begin
      pa_latch_reg <= PWDATA[PA_W-1:0];
    end else if (wr_commit && idx == IDX_PORT_B) begin
      pb_latch_reg <= PWDATA[PB_W-1:0];
    end else if (bop_go && !bop_port_b) begin
      pa_latch_reg <= bop_result[PA_W-1:0];
    end else if (bop_go && bop_port_b) begin
      pb_latch_reg <= bop_result;
    end
  end

  // Direction registers
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      pa_dir_reg <= DIR_A_RST;
      pb_dir_reg <= DIR_B_RST;
    end else if (wr_commit && idx == IDX_DIR_A) begin
      pa_dir_reg <= PWDATA[PA_W-1:0];
    end else if (wr_commit && idx == IDX_DIR_B) begin
      pb_dir_reg <= PWDATA[PB_W-1:0];
    end
  end

  // Option, comparator and reference controls
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      option_reg     <= OPTION_RST;
      cmp_ctl_reg    <= CMP_RST;
      vref_reg       <= VREF_RST;
      ext_int_en_reg <= 1'b0;
    end else if (wr_commit) begin
      case (idx)
        IDX_OPTION:  option_reg     <= PWDATA[DAT_W-1:0];
        IDX_CMP_CTL: cmp_ctl_reg    <= PWDATA[3:0];
        IDX_VREF:    vref_reg       <= PWDATA[DAT_W-1:0] & VREF_MASK;
        IDX_INT_CTL: ext_int_en_reg <= PWDATA[INT_EXT_EN_BIT];
        default:     option_reg     <= option_reg;
      endcase
    end
  end

  // Any B read (at sample time) or write refreshes the change reference
  assign pb_touch = (setup & ~PWRITE & mapped & (idx == IDX_PORT_B))
                  | (wr_commit & (idx == IDX_PORT_B))
                  | (bop_go & bop_port_b);

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      change_ref_reg <= 4'h0;
    end else if (pb_touch) begin
      change_ref_reg <= I_PB_PIN[CHG_LSB +: 4];
    end
  end

  // Mismatch only on input-configured upper pins; a change landing on the
  // sample edge refreshes the reference and still sets the change flag
  assign mismatch = |((I_PB_PIN[CHG_LSB +: 4] ^ change_ref_reg)
                      & pb_dir_reg[CHG_LSB +: 4]);
  assign flag_write = wr_commit & (idx == IDX_INT_CTL);

  // Set beats a same-cycle clear so no change is lost
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      change_flag_reg <= 1'b0;
    end else if (mismatch) begin
      change_flag_reg <= 1'b1;
    end else if (flag_write) begin
      change_flag_reg <= PWDATA[INT_FLAG_BIT];
    end
  end

  // Pad stages; A4 is open drain, A3/A4 carry comparator outputs in one mode
  for (genvar i = 0; i < PA_W; i++) begin : g_pa
    gpio_pin_cell #(.OPEN_DRAIN(i == PA_W - 1)) u_cell (
      .i_dir_in   (pa_dir_reg[i]),
      .i_latch    (pa_latch_reg[i]),
      .i_alt_en   (cmp_pin_out && (i >= 3)),
      .i_alt_val  (I_CMP_OUT[(i >= 4) ? 1 : 0]),
      .i_force_off(1'b0),
      .o_out      (O_PA_OUT[i]),
      .o_oe       (O_PA_OE[i])
    );
  end

  // B6/B7 drivers released to the programmer in programming mode
  for (genvar i = 0; i < PB_W; i++) begin : g_pb
    gpio_pin_cell #(.OPEN_DRAIN(1'b0)) u_cell (
      .i_dir_in   (pb_dir_reg[i]),
      .i_latch    (pb_latch_reg[i]),
      .i_alt_en   (1'b0),
      .i_alt_val  (1'b0),
      .i_force_off(I_PROG_MODE && (i >= 6)),
      .o_out      (O_PB_OUT[i]),
      .o_oe       (O_PB_OE[i])
    );
  end

  // Pull-ups: global active-low enable, masked off on output pins
  assign O_PB_PULLUP = {PB_W{~option_reg[OPT_PULLUP_N_BIT]}} & pb_dir_reg;

  // Buffer choice and alternate-function taps
  assign O_PB_SCHMITT    = {I_PROG_MODE, I_PROG_MODE, 5'h00, ext_int_en_reg};
  assign O_EXT_INT_IN    = I_PB_PIN[0];
  assign O_EXT_INT_EN    = ext_int_en_reg;
  assign O_PROG_CLK      = I_PB_PIN[6];
  assign O_PROG_DATA     = I_PB_PIN[7];
  assign O_TIMER_EXT_CLK = I_PA_PIN[4];
  assign O_CMP_CTL       = cmp_ctl_reg;
  assign O_VREF_CTL      = vref_reg;
  assign O_VREF_PIN_EN   = vref_reg[VREF_EN_BIT] & vref_reg[VREF_OE_BIT];
  assign O_CHANGE_FLAG   = change_flag_reg;
  assign O_WAKE          = change_flag_reg & I_SLEEP;

  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  sequence s_pb_read_setup;
    setup && !PWRITE && mapped && idx == IDX_PORT_B;
  endsequence

  sequence s_pb_access;
    PSEL && PENABLE;
  endsequence

  a_pb_read_pins: assert property (
    s_pb_read_setup ##1 s_pb_access |-> PRDATA[7:0] == $past(I_PB_PIN))
    else $error("Port B read does not return sampled pins");

  a_pb_oe_dir: assert property (!I_PROG_MODE |-> O_PB_OE == ~pb_dir_reg)
    else $error("Port B enable disagrees with direction");

  a_bitop_rmw: assert property (
    bop_go && bop_port_b && bop_kind == BOP_SET
    |=> pb_latch_reg == ($past(I_PB_PIN) | (8'h01 << $past(bop_bit))))
    else $error("Bit set did not rebuild latch from pins");

  a_pullup_output: assert property (
    !option_reg[OPT_PULLUP_N_BIT] |-> (O_PB_PULLUP == pb_dir_reg))
    else $error("Pull-up left on an output pin");

  a_option_reset: assert property ($past(I_SYS_RST) |->
    option_reg == OPTION_RST && O_PB_PULLUP == 8'h00 && pb_dir_reg == DIR_B_RST)
    else $error("Option or direction not at reset value");

  a_change_sets: assert property (mismatch |=> change_flag_reg[*2])
    else $error("Change flag not set by mismatch");

  a_change_excluded: assert property (
    pb_dir_reg[7:4] == 4'h0 && !change_flag_reg && !flag_write
    |=> !change_flag_reg)
    else $error("Output pin raised the change flag");

  a_ref_reload: assert property (
    pb_touch |=> change_ref_reg == $past(I_PB_PIN[7:4]))
    else $error("Change reference not reloaded on access");

  a_clear_after_touch: assert property (
    pb_touch ##1 ($stable(I_PB_PIN[7:4]) && !pb_touch && !flag_write)[*3]
    ##1 (flag_write && !PWDATA[INT_FLAG_BIT] && $stable(I_PB_PIN[7:4]))
    |=> !change_flag_reg)
    else $error("Flag not cleared after port B access");

  a_ra4_open_drain: assert property (
    O_PA_OUT[4] == 1'b0 && (!O_PA_OE[4] || !pa_dir_reg[4]))
    else $error("A4 driven high or without direction");

  a_analog_zero: assert property (
    setup && !PWRITE && idx == IDX_PORT_A && analog_mask == 4'hf
    |=> PRDATA[3:0] == 4'h0 && PRDATA[7:5] == 3'h0)
    else $error("Analog A pins not read as zero");

  a_wake_on_flag: assert property (mismatch && I_SLEEP ##1 I_SLEEP |-> O_WAKE)
    else $error("Change flag failed to wake");

endmodule : gpio_dual_port

`default_nettype wire

// ---- verif/gpio_pin_model.sv ----
// Board model for the dual GPIO port: pads, keypad drive and weak pull-ups.
// Assumes oe high means the device drives; a released, unpulled line wanders.
`default_nettype none

module gpio_pin_model (
  input  wire logic                      i_clk,       // Bench clock
  input  wire logic [gpio_pkg::PA_W-1:0] i_pa_out,    // A pad values
  input  wire logic [gpio_pkg::PA_W-1:0] i_pa_oe,     // A pad enables
  input  wire logic [gpio_pkg::PA_W-1:0] i_pa_ext,    // Board level on A
  input  wire logic [gpio_pkg::PB_W-1:0] i_pb_out,    // B pad values
  input  wire logic [gpio_pkg::PB_W-1:0] i_pb_oe,     // B pad enables
  input  wire logic [gpio_pkg::PB_W-1:0] i_pb_pullup, // B weak pull-ups
  input  wire logic [gpio_pkg::PB_W-1:0] i_pb_ext,    // Keypad level on B
  input  wire logic [gpio_pkg::PB_W-1:0] i_pb_ext_en, // Keypad drives B
  output var  logic [gpio_pkg::PA_W-1:0] o_pa_pin,    // Resolved A levels
  output var  logic [gpio_pkg::PB_W-1:0] o_pb_pin     // Resolved B levels
);
  timeunit 1ns;
  timeprecision 1ns;
  import gpio_pkg::*;

  logic [PB_W-1:0] float_reg; // Pattern on released lines

  // Floating lines toggle so a stale value never reads back by luck
  initial begin
    float_reg = 8'h55;
  end
  always @(posedge i_clk) begin
    float_reg <= ~float_reg;
  end

  // Device drive wins; A4 open drain only ever pulls low
  always_comb begin
    o_pa_pin = (i_pa_oe & i_pa_out) | (~i_pa_oe & i_pa_ext);
    o_pb_pin = (i_pb_oe & i_pb_out) | (~i_pb_oe & i_pb_ext_en & i_pb_ext)
             | (~i_pb_oe & ~i_pb_ext_en & (i_pb_pullup | float_reg));
  end
endmodule : gpio_pin_model

`default_nettype wire

// ---- verif/gpio_dual_port_tb.sv ----
// Directed bench for the dual GPIO port over APB, with a board pin model.
// Assumes the slave may stretch transfers; waits are cut by a cycle timeout.
`default_nettype none

module gpio_dual_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gpio_pkg::*;

  logic            clk, sys_rst, por_flag, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rdat;
  logic [3:0]      pstrb;
  logic [PA_W-1:0] pa_pin, pa_out, pa_oe, pa_ext;
  logic [PB_W-1:0] pb_pin, pb_out, pb_oe, pb_pullup, pb_schmitt, pb_ext, pb_ext_en;
  logic [1:0]      cmp_out;
  logic [3:0]      cmp_ctl;
  logic [7:0]      vref_ctl;
  logic            prog_mode, sleep_in, timer_clk, ext_int_in, ext_int_en;
  logic            prog_clk, prog_data, chg_flag, wake, vref_pin_en;
  int              num_errors, checks, cycles;

  gpio_dual_port u_dut (
    .I_CLK(clk), .I_SYS_RST(sys_rst), .I_POR_FLAG(por_flag), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .I_PA_PIN(pa_pin),
    .O_PA_OUT(pa_out), .O_PA_OE(pa_oe), .I_PB_PIN(pb_pin), .O_PB_OUT(pb_out),
    .O_PB_OE(pb_oe), .O_PB_PULLUP(pb_pullup), .O_PB_SCHMITT(pb_schmitt),
    .I_CMP_OUT(cmp_out), .I_PROG_MODE(prog_mode), .I_SLEEP(sleep_in), .O_CMP_CTL(cmp_ctl),
    .O_VREF_CTL(vref_ctl), .O_VREF_PIN_EN(vref_pin_en), .O_TIMER_EXT_CLK(timer_clk),
    .O_EXT_INT_IN(ext_int_in), .O_EXT_INT_EN(ext_int_en), .O_PROG_CLK(prog_clk),
    .O_PROG_DATA(prog_data), .O_CHANGE_FLAG(chg_flag), .O_WAKE(wake)
  );

  gpio_pin_model u_board (
    .i_clk(clk), .i_pa_out(pa_out), .i_pa_oe(pa_oe), .i_pa_ext(pa_ext),
    .i_pb_out(pb_out), .i_pb_oe(pb_oe), .i_pb_pullup(pb_pullup), .i_pb_ext(pb_ext),
    .i_pb_ext_en(pb_ext_en), .o_pa_pin(pa_pin), .o_pb_pin(pb_pin)
  );

  // 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdat, exp);
  endtask : rd_chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // Whole run is under two hundred cycles; this ceiling catches a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    pstrb     = 4'h1;
    cmp_out   = 2'h1;
    prog_mode = 1'b0;
    sleep_in  = 1'b0;
    pa_ext    = 5'h1a;
    pb_ext    = 8'h30;
    pb_ext_en = 8'hf0;   // Keypad holds the upper group
    {num_errors, checks} = 0;
    por_flag  = 1'b1;
    sys_rst   = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst   <= 1'b0;
    por_flag  <= 1'b0;
    @(negedge clk);
    chk(32'({pb_pullup, pb_oe, pa_oe}), 32'h0);
    rd_chk(IDX_DIR_A, 32'h1f);
    rd_chk(IDX_PORT_A, 32'h10);
    rd_chk(IDX_DIR_B, 32'hff);
    rd_chk(IDX_OPTION, 32'hff);
    rd_chk(8'h40, 32'h0);
    chk(32'(rerr), 32'h1);
    $display("test reset and map done");
    wr(IDX_VREF, 32'hff);
    rd_chk(IDX_VREF, 32'hef);
    chk(32'({vref_pin_en, vref_ctl}), 32'h1ef);
    wr(IDX_DIR_A, 32'he0);
    rd_chk(IDX_DIR_A, 32'h00);
    wr(IDX_PORT_A, 32'h15);
    @(negedge clk);
    chk(32'({pa_oe, pa_out}), 32'h1e5);
    rd_chk(IDX_PORT_A, 32'h10);
    wr(IDX_CMP_CTL, 32'h07);
    rd_chk(IDX_CMP_CTL, 32'h47);
    rd_chk(IDX_PORT_A, 32'h15);
    wr(IDX_CMP_CTL, 32'h06);
    @(negedge clk);
    chk(32'({cmp_ctl, pa_oe, pa_out}), 32'h1bed);
    wr(IDX_CMP_CTL, 32'h07);
    wr(IDX_DIR_A, 32'h1f);
    rd_chk(IDX_PORT_A, 32'h1a);
    chk(32'({pa_oe, timer_clk}), 32'h1);
    $display("test port a done");
    wr(IDX_DIR_B, 32'hf0);
    wr(IDX_PORT_B, 32'ha5);
    wr(IDX_OPTION, 32'h7f);
    @(negedge clk);
    chk(32'({pb_oe, pb_out & pb_oe}), 32'h0f05);
    chk(32'(pb_pullup), 32'hf0);
    rd_chk(IDX_PORT_B, 32'h35);
    wr(IDX_INT_CTL, 32'h0);
    $display("test port b done");
    // No polling of the port while waiting for a change
    @(posedge clk);
    pb_ext <= 8'h70;
    repeat (2) @(negedge clk);
    chk(32'(chg_flag), 32'h1);
    chk(32'(wake), 32'h0);
    @(posedge clk);
    sleep_in <= 1'b1;
    @(negedge clk);
    chk(32'(wake), 32'h1);
    repeat (2) @(posedge clk);
    sleep_in <= 1'b0;
    wr(IDX_INT_CTL, 32'h0);
    @(negedge clk);
    chk(32'(chg_flag), 32'h1);
    rd_chk(IDX_PORT_B, 32'h75);
    wr(IDX_INT_CTL, 32'h0);
    rd_chk(IDX_INT_CTL, 32'h0);
    @(posedge clk);
    pb_ext <= 8'h50;
    rd_chk(IDX_PORT_B, 32'h55);
    wr(IDX_INT_CTL, 32'h0);
    wr(IDX_DIR_B, 32'hd0);   // Bit 5 now drives its latch, unlike the reference
    repeat (3) @(negedge clk);
    chk(32'(chg_flag), 32'h0);
    $display("test change flag done");
    wr(IDX_BIT_OP, 32'({BOP_SET, 1'b1, 3'd1}));
    wr(IDX_BIT_OP, 32'({BOP_CLEAR, 1'b1, 3'd0}));
    wr(IDX_BIT_OP, 32'({BOP_TOGGLE, 1'b1, 3'd7}));
    wr(IDX_DIR_B, 32'h00);
    @(negedge clk);
    chk(32'({pb_oe, pb_out}), 32'hfff6);
    rd_chk(IDX_PORT_B, 32'hf6);
    $display("test bit operations done");
    wr(IDX_INT_CTL, 32'h10);
    prog_mode <= 1'b1;
    @(negedge clk);
    chk(32'({pb_schmitt, ext_int_en, ext_int_in}), 32'h306);
    chk(32'({pb_oe, prog_data, prog_clk}), 32'hfd);
    @(posedge clk);
    prog_mode <= 1'b0;
    $display("test alternate functions done");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk(32'({pb_pullup, pb_oe}), 32'h0);
    rd_chk(IDX_OPTION, 32'hff);
    wr(IDX_DIR_B, 32'h00);
    @(negedge clk);
    chk(32'(pb_out), 32'hf6);
    $display("test warm reset done");
    end_sim();
  end
endmodule : gpio_dual_port_tb

`default_nettype wire
